// ===== hw/isp_regs.svh
// Constants of the serial programming port: instruction codes,
// erased value, fuse reset values and self-timed write durations.
// Assumes it is included by bare name from hw/ files only.
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// First instruction byte
`define OP_PREFIX 8'hac
`define OP_POLL 8'hf0
`define OP_LD_LO 8'h40
`define OP_LD_HI 8'h48
`define OP_LD_EE 8'hc1
`define OP_RD_LO 8'h20
`define OP_RD_HI 8'h28
`define OP_RD_EE 8'ha0
`define OP_RD_LOCK 8'h58
`define OP_RD_SIG 8'h30
`define OP_RD_FUSE 8'h50
`define OP_WR_PAGE 8'h4c
`define OP_WR_EE 8'hc0
`define OP_WR_EE_PAGE 8'hc2

////////////////////////////////////////////////////////////////////////////////
// Second byte after the prefix, and the high-fuse selector
`define OP2_ENABLE 8'h53
`define OP2_ERASE 8'h80
`define OP2_W_LOCK 8'he0
`define OP2_W_FUSE 8'ha0
`define OP2_W_FUSE_HI 8'ha8
`define OP2_W_FUSE_EXT 8'ha4
`define OP2_HI_SEL 8'h08

////////////////////////////////////////////////////////////////////////////////
// Values and fields
`define ERASED_BYTE 8'hff
`define ERASED_WORD 16'hffff
`define FUSE_RST 8'hff
`define LOCK_RST 8'hff
`define POLL_BUSY_BIT 0

////////////////////////////////////////////////////////////////////////////////
// Self-timed durations in microseconds and the core clock rate
`define CLK_MHZ 125
`define FLASH_WAIT_US 2600
`define EE_WAIT_US 3600
`define ERASE_WAIT_US 10500
`define FUSE_WAIT_US 4500
`define WAIT_CNT_W 24

`endif

// ===== hw/isp_pkg.sv
// Types shared by the serial programming port modules.
// Assumes isp_regs.svh sits beside it in hw/.
`default_nettype none

package isp_pkg;
	// One four-byte serial instruction, first byte on top
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] a_hi;
		logic [7:0] a_lo;
		logic [7:0] data;
	} isp_frame_t;

	// Core sequencing states
	typedef enum logic [1:0] {st_off, st_idle, st_commit, st_wait} isp_state_t;

	// What the commit walker writes
	typedef enum logic [1:0] {wk_erase, wk_flash, wk_eepage} walk_t;
endpackage : isp_pkg

`default_nettype wire

// ===== hw/bit_sync.sv
// Two-flop level synchroniser into the core clock domain.
// Assumes inputs are levels that hold for several core cycles.
`default_nettype none

module bit_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First flop feeds only the second
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : bit_sync

`default_nettype wire

// ===== hw/isp_link.sv
// Serial shifter on the programmer's clock: bytes in on rising edges,
// reply bits out on falling edges.
// Assumes the reply byte is stable at each byte boundary's falling edge.
`default_nettype none

module isp_link (
	input wire logic sck,
	input wire logic link_clear,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic [7:0] rx_byte,
	output logic rx_tog,
	output logic miso
);
	logic [2:0] bit_reg;
	logic [6:0] shift_reg;
	logic [6:0] tx_reg;

	////////////////////////////////////////////////////////////////////////////////
	// The clock stops between frames, so clearing is asynchronous, on the reset pin
	// or core reset going high
	always_ff @(posedge sck or posedge link_clear) begin
		if (link_clear) begin
			bit_reg <= 3'h0;
			shift_reg <= 7'h00;
			rx_byte <= 8'h00;
			rx_tog <= 1'b0;
		end else begin
			shift_reg <= {shift_reg[5:0], mosi};
			bit_reg <= bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				rx_byte <= {shift_reg, mosi};
				rx_tog <= ~rx_tog; // Event crosses as a toggle
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// falling edge drive
	always_ff @(negedge sck or posedge link_clear) begin
		if (link_clear) begin
			miso <= 1'b0;
			tx_reg <= 7'h00;
		end else if (bit_reg == 3'h0) begin
			miso <= reply[7];
			tx_reg <= reply[6:0];
		end else begin
			miso <= tx_reg[6];
			tx_reg <= {tx_reg[5:0], 1'b0};
		end
	end
endmodule : isp_link

`default_nettype wire

// ===== hw/isp_port.sv
// Serial in-system programming port: decodes four-byte instructions,
// holds the flash and EEPROM arrays with page buffers, fuses and lock.
// Assumes sck, mosi and prog_reset_n come from the external programmer.
`default_nettype none
`include "isp_regs.svh"

module isp_port import isp_pkg::*; #(
	parameter int PAGE_W = 7,
	parameter int OFS_W = 6,
	parameter int FLASH_WAIT = `FLASH_WAIT_US * `CLK_MHZ,
	parameter int EE_WAIT = `EE_WAIT_US * `CLK_MHZ,
	parameter int ERASE_WAIT = `ERASE_WAIT_US * `CLK_MHZ,
	parameter int FUSE_WAIT = `FUSE_WAIT_US * `CLK_MHZ,
	parameter logic [7:0] SIG0 = 8'h5a, // Arbitrary identity value
	parameter logic [7:0] SIG1 = 8'h01, // Arbitrary identity value
	parameter logic [7:0] SIG2 = 8'h02 // Arbitrary identity value
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic prog_reset_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	output logic normal_run
);
	localparam int AW = PAGE_W + OFS_W;
	localparam int DEPTH = 1 << AW;
	localparam int PG = 1 << OFS_W;
	localparam int CW = `WAIT_CNT_W;
	logic link_clear, link_tog, tog_s, rst_n_s, tog_seen_reg, in_ses_reg, session;
	logic byte_ev, frame_done, can_run, busy, pe_reg, walk_last;
	logic [7:0] rx_byte, reply_reg, fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;
	logic [1:0] byte_idx_reg;
	isp_frame_t frame_reg, cur;
	isp_state_t state_reg;
	walk_t walk_reg;
	logic [AW-1:0] ptr_reg, cur_addr;
	logic [PAGE_W-1:0] page_reg;
	logic [CW-1:0] wait_reg, pend_reg;
	logic [OFS_W-1:0] ld_ofs, wofs;
	logic [PG-1:0] ebuf_ld_reg;
	logic [15:0] flash_mem [DEPTH];
	logic [7:0] ee_mem [DEPTH];
	logic [15:0] fbuf [PG];
	logic [7:0] ebuf [PG];
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	// Word or byte address from the two middle instruction bytes
	function automatic logic [AW-1:0] addr_of(input logic [7:0] hi, input logic [7:0] lo);
		logic [15:0] a;
		a = {hi, lo};
		return a[AW-1:0];
	endfunction : addr_of
	// Cycle count from a period parameter, cut to the timer width
	function automatic logic [CW-1:0] cycles(input int n);
		return CW'(n);
	endfunction : cycles
	// Reply byte for the fourth instruction byte
	function automatic logic [7:0] read_value(input logic [7:0] op, input logic [7:0] hi,
			input logic [7:0] lo);
		logic [AW-1:0] a;
		logic [7:0] v;
		a = addr_of(hi, lo);
		v = 8'h00;
		case (op)
			`OP_RD_LO: v = flash_mem[a][7:0];
			`OP_RD_HI: v = flash_mem[a][15:8];
			`OP_RD_EE: v = ee_mem[a];
			`OP_RD_LOCK: v = (hi == `OP2_HI_SEL) ? fuse_hi_reg : lock_reg;
			`OP_RD_FUSE: v = (hi == `OP2_HI_SEL) ? fuse_ext_reg : fuse_lo_reg;
			`OP_RD_SIG: begin
				case (lo[1:0])
					2'h0: v = SIG0;
					2'h1: v = SIG1;
					default: v = SIG2;
				endcase
			end
			`OP_POLL: v[`POLL_BUSY_BIT] = busy;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_value
	////////////////////////////////////////////////////////////////////////////////
	// Link domain and crossings
	// Core reset also clears the link, since the pin may sit low from power-up
	assign link_clear = reset | prog_reset_n;
	isp_link u_link (
		.sck(sck),
		.link_clear(link_clear),
		.mosi(mosi),
		.reply(reply_reg),
		.rx_byte(rx_byte),
		.rx_tog(link_tog),
		.miso(miso)
	);
	bit_sync #(.W(2), .INIT(2'b01)) u_sync (
		.clock(clock),
		.reset(reset),
		.d({link_tog, prog_reset_n}),
		.q({tog_s, rst_n_s})
	);
	assign session = ~rst_n_s;
	// Byte data is stable for a whole byte time once its toggle is seen
	assign byte_ev = (tog_s != tog_seen_reg) && session && in_ses_reg;
	assign frame_done = byte_ev && (byte_idx_reg == 2'h3);
	assign cur = {frame_reg.op, frame_reg.a_hi, frame_reg.a_lo, rx_byte};
	assign busy = (state_reg == st_commit) || (state_reg == st_wait);
	assign can_run = frame_done && pe_reg && (state_reg == st_idle);
	assign ld_ofs = cur.a_lo[OFS_W-1:0];
	assign wofs = ptr_reg[OFS_W-1:0];
	assign walk_last = (walk_reg == wk_erase) ? (ptr_reg == AW'(DEPTH - 1))
		: (wofs == OFS_W'(PG - 1));
	assign cur_addr = addr_of(cur.a_hi, cur.a_lo);
	// Edge tracking and session qualifiers
	always_ff @(posedge clock) begin
		if (reset) begin
			tog_seen_reg <= 1'b0;
			in_ses_reg <= 1'b0;
		end else begin
			tog_seen_reg <= tog_s;
			in_ses_reg <= session;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			normal_run <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			normal_run <= ~session;
			miso_oe <= session;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Instruction framing
	// four-byte frames
	always_ff @(posedge clock) begin
		if (reset || !session) begin
			byte_idx_reg <= 2'h0;
			frame_reg <= '0;
		end else if (byte_ev) begin
			byte_idx_reg <= byte_idx_reg + 2'h1;
			case (byte_idx_reg)
				2'h0: frame_reg.op <= rx_byte;
				2'h1: frame_reg.a_hi <= rx_byte;
				2'h2: frame_reg.a_lo <= rx_byte;
				default: frame_reg.data <= rx_byte;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (reset || !session) begin
			pe_reg <= 1'b0;
		end else if (frame_done && cur.op == `OP_PREFIX && cur.a_hi == `OP2_ENABLE) begin
			pe_reg <= 1'b1;
		end
	end
	// Reply is the previous byte, except the data slot of the frame
	// echo second byte
	always_ff @(posedge clock) begin
		if (reset || !session) begin
			reply_reg <= 8'h00;
		end else if (byte_ev) begin
			if (byte_idx_reg == 2'h2) begin
				reply_reg <= read_value(frame_reg.op, frame_reg.a_hi, rx_byte);
			end else begin
				reply_reg <= rx_byte;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: self-timed writes; frames other than reads and program enable are ignored while busy
	// busy until timer ends
	always_ff @(posedge clock) begin
		if (reset || !session) begin
			state_reg <= st_off;
			walk_reg <= wk_erase;
			page_reg <= '0;
			pend_reg <= '0;
		end else begin
			case (state_reg)
				st_off: state_reg <= st_idle;
				st_idle: begin
					if (can_run) begin
						page_reg <= cur_addr[AW-1:OFS_W];
						if (cur.op == `OP_PREFIX && cur.a_hi == `OP2_ERASE) begin
							walk_reg <= wk_erase;
							pend_reg <= cycles(ERASE_WAIT);
							state_reg <= st_commit;
						end else if (cur.op == `OP_WR_PAGE) begin
							walk_reg <= wk_flash;
							pend_reg <= cycles(FLASH_WAIT);
							state_reg <= st_commit;
						end else if (cur.op == `OP_WR_EE_PAGE) begin
							walk_reg <= wk_eepage;
							pend_reg <= cycles(EE_WAIT);
							state_reg <= st_commit;
						end else if (cur.op == `OP_WR_EE) begin
							pend_reg <= cycles(EE_WAIT);
							state_reg <= st_wait;
						end else if (cur.op == `OP_PREFIX && (cur.a_hi == `OP2_W_FUSE
								|| cur.a_hi == `OP2_W_FUSE_HI || cur.a_hi == `OP2_W_FUSE_EXT
								|| cur.a_hi == `OP2_W_LOCK)) begin
							pend_reg <= cycles(FUSE_WAIT);
							state_reg <= st_wait;
						end
					end
				end
				st_commit: state_reg <= walk_last ? st_wait : st_commit;
				// Single writes enter with the timer at zero, so leave only on its last count
				st_wait: state_reg <= (wait_reg == CW'(1)) ? st_idle : st_wait;
				default: state_reg <= st_off;
			endcase
		end
	end
	// Walk pointer and write timer
	always_ff @(posedge clock) begin
		if (reset || state_reg == st_idle || state_reg == st_off) begin
			ptr_reg <= '0;
			wait_reg <= '0;
		end else if (state_reg == st_commit) begin
			ptr_reg <= ptr_reg + AW'(1);
			wait_reg <= pend_reg;
		end else if (wait_reg == '0) begin
			wait_reg <= pend_reg; // Single writes skip the walk
		end else begin
			wait_reg <= wait_reg - CW'(1);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Arrays and buffers
	// erase to ones
	always_ff @(posedge clock) begin
		if (state_reg == st_commit && walk_reg == wk_erase) begin
			flash_mem[ptr_reg] <= `ERASED_WORD;
		end else if (state_reg == st_commit && walk_reg == wk_flash) begin
			flash_mem[{page_reg, wofs}] <= fbuf[wofs];
		end
	end
	always_ff @(posedge clock) begin
		if (state_reg == st_commit && walk_reg == wk_erase) begin
			ee_mem[ptr_reg] <= `ERASED_BYTE;
		end else if (state_reg == st_commit && walk_reg == wk_eepage) begin
			if (ebuf_ld_reg[wofs]) begin
				ee_mem[{page_reg, wofs}] <= ebuf[wofs];
			end
		end else if (can_run && cur.op == `OP_WR_EE) begin
			ee_mem[addr_of(cur.a_hi, cur.a_lo)] <= cur.data;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			fbuf <= '{default: `ERASED_WORD}; // Unloaded words must program as blank
		end else if (state_reg == st_commit && walk_reg == wk_flash) begin
			fbuf[wofs] <= `ERASED_WORD; // Buffer reads as blank after commit
		end else if (can_run && cur.op == `OP_LD_LO) begin
			fbuf[ld_ofs][7:0] <= cur.data;
		end else if (can_run && cur.op == `OP_LD_HI) begin
			fbuf[ld_ofs][15:8] <= cur.data;
		end
	end
	// EEPROM page buffer data and its loaded marks
	always_ff @(posedge clock) begin
		if (can_run && cur.op == `OP_LD_EE) begin
			ebuf[ld_ofs] <= cur.data;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ebuf_ld_reg <= '0;
		end else if (state_reg == st_commit && walk_reg == wk_eepage) begin
			ebuf_ld_reg[wofs] <= 1'b0;
		end else if (can_run && cur.op == `OP_LD_EE) begin
			ebuf_ld_reg[ld_ofs] <= 1'b1;
		end
	end
	// Fuses and lock; only chip erase and core reset release the lock
	always_ff @(posedge clock) begin
		if (reset) begin
			fuse_lo_reg <= `FUSE_RST;
			fuse_hi_reg <= `FUSE_RST;
			fuse_ext_reg <= `FUSE_RST;
			lock_reg <= `LOCK_RST;
		end else if (state_reg == st_commit && walk_reg == wk_erase) begin
			lock_reg <= `LOCK_RST;
		end else if (can_run && cur.op == `OP_PREFIX) begin
			case (cur.a_hi)
				`OP2_W_FUSE: fuse_lo_reg <= cur.data;
				`OP2_W_FUSE_HI: fuse_hi_reg <= cur.data;
				`OP2_W_FUSE_EXT: fuse_ext_reg <= cur.data;
				`OP2_W_LOCK: lock_reg <= lock_reg & cur.data;
				default: lock_reg <= lock_reg;
			endcase
		end
	end
endmodule : isp_port

`default_nettype wire

// ===== dv/isp_port_assertions.sv
// Port assertions for the serial programming port, bound to isp_port.
// Assumes each sck phase lasts several core clock cycles.
`default_nettype none

module isp_port_checker (
	input wire logic clock,
	input wire logic reset,
	input wire logic prog_reset_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic normal_run
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] bit_cnt_reg;
	logic [14:0] rx_reg;
	logic [6:0] tx_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Bit position in the frame, cleared with the link so it tracks resync
	always_ff @(posedge sck or posedge prog_reset_n or posedge reset) begin
		if (prog_reset_n || reset) begin
			bit_cnt_reg <= 5'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Recent bits seen at each rising sck
	always_ff @(posedge sck) begin
		rx_reg <= {rx_reg[13:0], mosi};
		tx_reg <= {tx_reg[5:0], miso};
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_oe_rise;
		@(posedge clock) disable iff (reset) $fell(prog_reset_n) |-> ##[2:6] miso_oe;
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("miso_oe late after pin low");

	property p_in_session;
		@(posedge clock) disable iff (reset) (!prog_reset_n)[*6] |-> miso_oe && !normal_run;
	endproperty
	a_in_session: assert property (p_in_session)
		else $error("not in session while pin low");

	property p_off_session;
		@(posedge clock) disable iff (reset) prog_reset_n[*6] |-> normal_run && !miso_oe;
	endproperty
	a_off_session: assert property (p_off_session)
		else $error("not running while pin high");

	property p_run_cause;
		@(posedge clock) disable iff (reset)
			$rose(normal_run) |-> prog_reset_n && $past(prog_reset_n, 2);
	endproperty
	a_run_cause: assert property (p_run_cause)
		else $error("normal_run rose without pin high");

	property p_oe_cause;
		@(posedge clock) disable iff (reset)
			$rose(miso_oe) |-> !prog_reset_n && !$past(prog_reset_n, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("miso_oe rose without pin low");

	property p_miso_quiet;
		@(posedge clock) disable iff (reset) prog_reset_n && $past(prog_reset_n) |-> miso == 1'b0;
	endproperty
	a_miso_quiet: assert property (p_miso_quiet)
		else $error("miso active outside session");

	property p_miso_fall;
		@(posedge clock) disable iff (reset) $changed(miso) |-> !sck || prog_reset_n;
	endproperty
	a_miso_fall: assert property (p_miso_fall)
		else $error("miso changed while sck high");

	// Reply of slots two and three is the byte received just before
	property p_echo;
		@(posedge sck) disable iff (prog_reset_n || reset)
			(bit_cnt_reg == 5'h0f || bit_cnt_reg == 5'h17) |-> {tx_reg, miso} == rx_reg[14:7];
	endproperty
	a_echo: assert property (p_echo)
		else $error("reply byte is not the previous byte");
endmodule : isp_port_checker

`default_nettype wire

// ===== dv/isp_programmer.sv
// Model of the external programmer, master of the serial link.
// Assumes nothing of the core clock; its own timing is unrelated in phase.
`default_nettype none

module isp_programmer (
	input wire logic miso,
	output logic sck,
	output logic mosi,
	output logic prog_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// sck low; each start pulses the reset pin high
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		prog_reset_n = 1'b1;
	end

	// slow phases, msb first; sck idles low between frames
	task automatic xfer(input logic [31:0] f, output logic [31:0] r);
		#3.7;
		for (int i = 31; i >= 0; i--) begin
			mosi = f[i];
			#62.5 sck = 1'b1;
			r = {r[30:0], miso};
			#62.5 sck = 1'b0;
		end
		mosi = ~mosi; // Released line has no pull, so show the inverse
	endtask : xfer

	// enter a session, resend enable once after a bad echo
	task automatic start(input logic en, output logic [7:0] echo);
		logic [31:0] r;
		echo = 8'h00;
		for (int n = 0; n < 2 && echo !== 8'h53; n++) begin
			prog_reset_n = 1'b1;
			#100 prog_reset_n = 1'b0;
			#1000; // Settle time shortened to keep the run brief
			if (!en) return;
			xfer({8'hac, 8'h53, 16'h0000}, r);
			echo = r[15:8];
		end
	endtask : start

	task automatic leave();
		prog_reset_n = 1'b1;
	endtask : leave
endmodule : isp_programmer

`default_nettype wire

// ===== dv/tb_isp_port.sv
// Self-checking bench for the serial programming port.
// Assumes the programmer model drives the link; self-timed waits are shortened.
`default_nettype none

module tb_isp_port import isp_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAIT_CYC = 50;
	logic clock, reset, prog_reset_n, sck, mosi, miso, miso_oe, normal_run;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h00015065;
	logic [7:0] rd, e, hi, lo, ed;
	logic [12:0] ea;
	logic [6:0] pg;
	logic [5:0] ofs [3];
	logic [15:0] wd [3];

	always #4 clock = ~clock;

	isp_port #(.FLASH_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC), .ERASE_WAIT(WAIT_CYC),
		.FUSE_WAIT(WAIT_CYC)) DUT (.clock(clock), .reset(reset), .prog_reset_n(prog_reset_n),
		.sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .normal_run(normal_run));
	isp_programmer u_prog (.miso(miso), .sck(sck), .mosi(mosi), .prog_reset_n(prog_reset_n));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Expected byte of a loaded flash word
	function automatic logic [7:0] half(logic [15:0] w, logic h);
		return h ? w[15:8] : w[7:0];
	endfunction : half

	task automatic check(string n, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
			error_cnt++;
		end
	endtask : check

	// One instruction; the core gets a few cycles before the next frame
	task automatic cmd(input logic [7:0] b1, b2, b3, b4, output logic [7:0] r4);
		isp_frame_t f;
		logic [31:0] r;
		f = '{op: b1, a_hi: b2, a_lo: b3, data: b4};
		u_prog.xfer(f, r);
		r4 = r[7:0];
		repeat (8) @(posedge clock);
		#1;
	endtask : cmd

	// Poll until idle, with a bounded number of tries
	task automatic wait_ready();
		logic [7:0] p;
		for (int n = 0; n < 100; n++) begin
			cmd(8'hf0, 8'h00, 8'h00, 8'h00, p);
			if (p[0] === 1'b0) return;
		end
		$display("CHECK FAILED ready expected 00 seen %h", p);
		error_cnt++;
		complete_run();
	endtask : wait_ready

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		repeat (6) @(posedge clock);
		#1 reset = 1'b0;
		u_prog.start(1'b1, e);
		check("echo", 8'h53, e);
		check("oe", 8'h01, {7'h00, miso_oe});
		cmd(8'hac, 8'h80, 8'h00, 8'h00, rd);
		cmd(8'hf0, 8'h00, 8'h00, 8'h00, rd);
		check("busy", 8'h01, {7'h00, rd[0]});
		wait_ready();
		for (int k = 0; k < 4; k++) begin
			ea = 13'(rnd());
			cmd(k[0] ? 8'h28 : 8'h20, {3'h0, ea[12:8]}, ea[7:0], 8'h00, rd);
			check("erased_flash", 8'hff, rd);
			cmd(8'ha0, {3'h0, ea[12:8]}, ea[7:0], 8'h00, rd);
			check("erased_eeprom", 8'hff, rd);
		end
		$display("test erase done");
		// Flash page with both boundary offsets
		pg = 7'(rnd());
		ofs[0] = 6'h00;
		ofs[1] = 6'h3f;
		ofs[2] = 6'h02 + 6'(rnd() % 60);
		for (int k = 0; k < 3; k++) begin
			wd[k] = 16'(rnd());
			cmd(8'h40, 8'h00, {2'h0, ofs[k]}, wd[k][7:0], rd);
			cmd(8'h48, 8'h00, {2'h0, ofs[k]}, wd[k][15:8], rd);
		end
		lo = 8'(rnd());
		cmd(8'h4c, {3'h0, pg[6:2]}, {pg[1:0], lo[5:0]}, 8'h00, rd);
		wait_ready();
		for (int k = 0; k < 6; k++) begin
			cmd(k[0] ? 8'h28 : 8'h20, {3'h0, pg[6:2]}, {pg[1:0], ofs[k / 2]}, 8'h00, rd);
			check("page", half(wd[k / 2], k[0]), rd);
		end
		cmd(8'h20, {3'h0, pg[6:2]}, {pg[1:0], 6'h01}, 8'h00, rd);
		check("page_unloaded", 8'hff, rd);
		$display("test flash page done");
		// EEPROM byte written twice: second value needs the auto-erase
		ea = 13'(rnd());
		hi = {3'h0, ea[12:8]};
		cmd(8'hc0, hi, ea[7:0], 8'h0f, rd);
		wait_ready();
		cmd(8'hc0, hi, ea[7:0], 8'hf0, rd);
		wait_ready();
		cmd(8'ha0, hi, ea[7:0], 8'h00, rd);
		check("ee_byte", 8'hf0, rd);
		$display("test eeprom byte done");
		// EEPROM page touching one neighbour only
		ed = 8'(rnd());
		lo = ea[7:0] ^ 8'h01;
		cmd(8'hc1, 8'h00, {2'h0, lo[5:0]}, ed, rd);
		cmd(8'hc2, hi, {ea[7:6], 6'h00}, 8'h00, rd);
		wait_ready();
		cmd(8'ha0, hi, lo, 8'h00, rd);
		check("ee_page", ed, rd);
		cmd(8'ha0, hi, ea[7:0], 8'h00, rd);
		check("ee_untouched", 8'hf0, rd);
		$display("test eeprom page done");
		// Low fuse written, then read back after the self-timed wait
		e = 8'(rnd());
		cmd(8'hac, 8'ha0, 8'h00, e, rd);
		wait_ready();
		cmd(8'h50, 8'h00, 8'h00, 8'h00, rd);
		check("fuse", e, rd);
		$display("test fuse done");
		// Leave, then try a write in a session without enable
		u_prog.leave();
		repeat (8) @(posedge clock);
		#1;
		check("run", 8'h01, {7'h00, normal_run});
		u_prog.start(1'b0, e);
		cmd(8'hc0, hi, ea[7:0], 8'h00, rd);
		repeat (100) @(posedge clock);
		u_prog.start(1'b1, e);
		cmd(8'ha0, hi, ea[7:0], 8'h00, rd);
		check("refused", 8'hf0, rd);
		$display("test refusal done");
		complete_run();
	end
endmodule : tb_isp_port

bind isp_port isp_port_checker u_chk (.clock(clock), .reset(reset), .prog_reset_n(prog_reset_n),
	.sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .normal_run(normal_run));

`default_nettype wire
